/* File: hw/ucg_pkg.sv */
package ucg_pkg;
   localparam int          UCG_DIV_W         = 12;
   localparam logic [11:0] UCG_DIV_RESET     = 12'h000;
   localparam logic [3:0]  UCG_FACTOR_NORMAL = 4'hf;   // 16 base ticks per bit.
   localparam logic [3:0]  UCG_FACTOR_DOUBLE = 4'h7;   // 8 base ticks per bit.
   localparam logic [3:0]  UCG_FACTOR_SYNC   = 4'h1;   // 2 base ticks per bit.
   localparam int          UCG_SYNC_STAGES   = 2;
   typedef enum logic [1:0] {
      UCG_MODE_ASYNC_NORMAL,
      UCG_MODE_ASYNC_DOUBLE,
      UCG_MODE_SYNC_MASTER,
      UCG_MODE_SYNC_SLAVE
   } ucg_mode_t;
endpackage

/* File: hw/ucg_baud_gen.sv */
// Down-counter prescaler: a one-cycle tick each time the count reaches zero without a divisor write.
module ucg_baud_gen
   import ucg_pkg::*;
#(
   parameter int DIV_W = UCG_DIV_W
) (
   input  wire logic             clk_in,       // System clock.
   input  wire logic             rst_b_in,     // Synchronous reset, active low.
   input  wire logic [DIV_W-1:0] divisor_in,   // Baud divisor.
   input  wire logic             reload_in,    // Low divisor byte written.
   output logic                  tick_out      // One pulse per divisor+1 cycles.
);
   logic [DIV_W-1:0] cnt_q, cnt_d;
   logic             tick_q, tick_d;

   always_comb begin
      tick_d = 1'b0;
      cnt_d  = cnt_q - 1'b1;
      if (reload_in) begin
         cnt_d = divisor_in;
      end else if (cnt_q == '0) begin
         cnt_d  = divisor_in;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         cnt_q  <= DIV_W'(UCG_DIV_RESET);
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick_out = tick_q;

   tick_period_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (cnt_q == '0 && !reload_in) |=> tick_q && cnt_q == $past(divisor_in))
      else $error("Baud tick missing or wrong reload at zero.");
   divisor_reload_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      reload_in |=> !tick_q && cnt_q == $past(divisor_in))
      else $error("Divisor write did not restart the count.");
endmodule

/* File: hw/ucg_clock_gen.sv */
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Four clock modes; sync select picks asynchronous or synchronous.
// - In sync mode, pin direction output means master, input means slave.
// - Transfer clock pin used only in synchronous mode.
// - Down-counter runs on system clock, reloads at zero or low-divisor write.
// - One baud tick at each zero without a low-divisor write: rate is clock over divisor plus one.
// - Receiver base clock is the baud tick outside slave mode; 16, 8 or 2 recovery states.
// - Bit rate divides baud tick by 16, 8 or 2 by mode.
// - Divisor is 12 bits from high and low bytes, 0 to 4095.
// - Double speed only affects asynchronous mode; software keeps it low in sync.
// - Double speed halves divider to 8 and receiver samples 8 per bit.
// - Slave clock is synchronised then edge detected, three cycles delay.
// - Baud generator times both asynchronous modes and master mode.
// - Slave mode clocks transmitter and receiver from external clock.
// - Polarity zero: change on rising, sample on falling; one reverses.
module ucg_clock_gen
   import ucg_pkg::*;
(
   input  wire logic        clk_in,              // 40 MHz system clock.
   input  wire logic        rst_b_in,            // Synchronous reset, active low.
   input  wire logic        sync_mode_select_in, // 1 selects synchronous mode.
   input  wire logic        double_speed_select_in, // Asynchronous double speed.
   input  wire logic        xfer_clock_direction_in, // 1 drives the pin (master).
   input  wire logic        sync_clock_polarity_in,  // Edge polarity in sync mode.
   input  wire logic [3:0]  baud_divisor_high_in, // Divisor bits 11..8.
   input  wire logic [7:0]  baud_divisor_low_in,  // Divisor bits 7..0.
   input  wire logic        divisor_low_wr_in,    // Low divisor byte write strobe.
   input  wire logic        transfer_clock_pin_in, // Pin level from outside.
   output logic             transfer_clock_pin_out, // Pin drive level.
   output logic             transfer_clock_pin_oe_out, // High while driving the pin.
   output logic             tx_clk_out,           // Transmitter bit clock enable.
   output logic             rx_clk_out,           // Receiver base clock enable.
   output logic             tx_change_out,        // Sync: data change edge.
   output logic             rx_sample_out,        // Sync: data sample edge.
   output logic [3:0]       rx_states_m1_out,     // Recovery states minus one.
   output logic [1:0]       mode_out              // Active clock mode.
);
   logic [UCG_DIV_W-1:0] divisor;
   logic                 baud_tick;
   ucg_mode_t            mode;
   logic [3:0]           factor;

   assign divisor = {baud_divisor_high_in, baud_divisor_low_in};

   ucg_baud_gen #(.DIV_W(UCG_DIV_W)) u_baud (
      .clk_in     (clk_in),
      .rst_b_in   (rst_b_in),
      .divisor_in (divisor),
      .reload_in  (divisor_low_wr_in),
      .tick_out   (baud_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode; double speed is ignored whenever sync mode is selected.
   always_comb begin
      if (!sync_mode_select_in) begin
         mode = double_speed_select_in ? UCG_MODE_ASYNC_DOUBLE
                                       : UCG_MODE_ASYNC_NORMAL;
      end else begin
         mode = xfer_clock_direction_in ? UCG_MODE_SYNC_MASTER
                                        : UCG_MODE_SYNC_SLAVE;
      end
      case (mode)
         UCG_MODE_ASYNC_NORMAL: factor = UCG_FACTOR_NORMAL;
         UCG_MODE_ASYNC_DOUBLE: factor = UCG_FACTOR_DOUBLE;
         default:               factor = UCG_FACTOR_SYNC;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // External clock: two-stage synchroniser, then an edge detector.
   logic [UCG_SYNC_STAGES-1:0] xs_q, xs_d;
   logic                       xprev_q, xprev_d;
   logic                       ext_rise, ext_fall;

   always_comb begin
      xs_d    = {xs_q[0], transfer_clock_pin_in};
      xprev_d = xs_q[1];
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         xs_q    <= '0;
         xprev_q <= 1'b0;
      end else begin
         xs_q    <= xs_d;
         xprev_q <= xprev_d;
      end
   end

   assign ext_rise = xs_q[1] & ~xprev_q;
   assign ext_fall = ~xs_q[1] & xprev_q;

   ////////////////////////////////////////////////////////////////////////////
   // Bit clock divider and the internal master clock level.
   // Outside slave mode the prescaler alone makes the receiver base; the divider makes bit rate.
   logic [3:0] div_q, div_d;
   logic       mclk_q, mclk_d;
   logic       tx_d, rx_d, chg_d, smp_d, pin_d, oe_d;
   logic       tx_q, rx_q, chg_q, smp_q, pin_q, oe_q;
   logic       int_rise, int_fall, eff_rise, eff_fall;

   always_comb begin
      div_d    = div_q;
      mclk_d   = mclk_q;
      int_rise = 1'b0;
      int_fall = 1'b0;
      tx_d     = 1'b0;
      if (mode != UCG_MODE_SYNC_SLAVE && baud_tick) begin
         if (div_q >= factor) begin
            div_d = '0;
            tx_d  = 1'b1;
         end else begin
            div_d = div_q + 1'b1;
         end
         if (mode == UCG_MODE_SYNC_MASTER) begin
            mclk_d   = ~mclk_q;
            int_rise = ~mclk_q;
            int_fall = mclk_q;
         end
      end
      if (mode != UCG_MODE_SYNC_MASTER) begin
         mclk_d = 1'b0;
      end
      eff_rise = (mode == UCG_MODE_SYNC_SLAVE) ? ext_rise : int_rise;
      eff_fall = (mode == UCG_MODE_SYNC_SLAVE) ? ext_fall : int_fall;
      if (mode == UCG_MODE_SYNC_SLAVE) begin
         div_d = '0;
         tx_d  = ext_rise | ext_fall;
      end
      rx_d  = (mode == UCG_MODE_SYNC_SLAVE) ? (ext_rise | ext_fall) : baud_tick;
      chg_d = sync_clock_polarity_in ? eff_fall : eff_rise;
      smp_d = sync_clock_polarity_in ? eff_rise : eff_fall;
      oe_d  = (mode == UCG_MODE_SYNC_MASTER);
      pin_d = oe_d & mclk_d;
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         div_q  <= '0;
         mclk_q <= 1'b0;
         tx_q   <= 1'b0;
         rx_q   <= 1'b0;
         chg_q  <= 1'b0;
         smp_q  <= 1'b0;
         pin_q  <= 1'b0;
         oe_q   <= 1'b0;
      end else begin
         div_q  <= div_d;
         mclk_q <= mclk_d;
         tx_q   <= tx_d;
         rx_q   <= rx_d;
         chg_q  <= chg_d;
         smp_q  <= smp_d;
         pin_q  <= pin_d;
         oe_q   <= oe_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered status outputs.
   logic [3:0] states_q;
   logic [1:0] mode_q;

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         states_q <= UCG_FACTOR_NORMAL;
         mode_q   <= 2'h0;
      end else begin
         states_q <= factor;
         mode_q   <= mode;
      end
   end

   assign tx_clk_out                = tx_q;
   assign rx_clk_out                = rx_q;
   assign tx_change_out             = chg_q;
   assign rx_sample_out             = smp_q;
   assign transfer_clock_pin_out    = pin_q;
   assign transfer_clock_pin_oe_out = oe_q;
   assign rx_states_m1_out          = states_q;
   assign mode_out                  = mode_q;

   ////////////////////////////////////////////////////////////////////////////
   pin_async_free_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !sync_mode_select_in |=> !transfer_clock_pin_oe_out)
      else $error("Pin driven outside synchronous mode.");
   rx_base_tick_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (baud_tick && mode != UCG_MODE_SYNC_SLAVE) |=> rx_clk_out)
      else $error("Receiver base clock lost a baud tick.");
   slave_edge_delay_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (mode == UCG_MODE_SYNC_SLAVE && $rose(xs_q[1])) |=> tx_clk_out)
      else $error("Slave edge not passed on.");
   slave_no_baud_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (mode == UCG_MODE_SYNC_SLAVE && !ext_rise && !ext_fall) |=> !tx_clk_out)
      else $error("Baud generator clocked slave mode.");
   slave_edge_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (mode == UCG_MODE_SYNC_SLAVE && (ext_rise || ext_fall))
      |=> rx_clk_out && tx_clk_out)
      else $error("Slave edge did not clock both directions.");
   master_pin_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (mode == UCG_MODE_SYNC_MASTER) |=> transfer_clock_pin_oe_out)
      else $error("Master mode does not drive the pin.");
   polarity_edge_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (mode == UCG_MODE_SYNC_MASTER && !sync_clock_polarity_in && int_rise)
      |=> tx_change_out && !rx_sample_out)
      else $error("Change edge does not follow polarity.");
   div_bound_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (mode == UCG_MODE_ASYNC_NORMAL && baud_tick && div_q >= UCG_FACTOR_NORMAL)
      |=> tx_clk_out && div_q == '0)
      else $error("Bit divider did not wrap after sixteen ticks.");
   double_div_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (mode == UCG_MODE_ASYNC_DOUBLE && baud_tick && div_q < UCG_FACTOR_DOUBLE)
      |=> !tx_clk_out && div_q == $past(div_q) + 4'h1)
      else $error("Double speed divider wrong.");
   sync_double_ignored_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      sync_mode_select_in |=> rx_states_m1_out == UCG_FACTOR_SYNC &&
      (mode_out == UCG_MODE_SYNC_MASTER || mode_out == UCG_MODE_SYNC_SLAVE))
      else $error("Double speed leaked into sync mode.");

   async_cov_c:  cover property (@(posedge clk_in) mode == UCG_MODE_ASYNC_NORMAL && tx_q);
   double_cov_c: cover property (@(posedge clk_in) mode == UCG_MODE_ASYNC_DOUBLE && tx_q);
   master_cov_c: cover property (@(posedge clk_in) $rose(pin_q));
   slave_cov_c:  cover property (@(posedge clk_in) mode == UCG_MODE_SYNC_SLAVE && smp_q);
endmodule

/* File: tb/ucg_ext_master.sv */
// Far-side synchronous master that drives the transfer clock in slave mode.
module ucg_ext_master (
   input  wire logic       clk_in,  // System clock used for timing.
   input  wire logic       run_in,  // High while a frame is being clocked.
   input  wire logic [3:0] half_in, // Half period in system cycles.
   output logic            pin_out  // Transfer clock level.
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_q = 4'h0;
   initial pin_out = 1'b0;
   // The clock stands still between frames; a half period of 3 or more keeps it
   // strictly below a quarter of the system clock.
   always @(posedge clk_in) begin
      if (!run_in) begin
         cnt_q <= 4'h0;
      end else if (cnt_q + 4'h1 >= half_in) begin
         cnt_q   <= 4'h0;
         pin_out <= ~pin_out;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule

/* File: tb/tb_ucg_clock_gen.sv */
module tb_ucg_clock_gen;
   timeunit 1ns;
   timeprecision 1ps;
   import ucg_pkg::*;
   logic clk_in, rst_b_in, sm, ds, dir, pol, wr, ext_run, ext_pin;
   logic [3:0] hi, half;
   logic [7:0] lo;
   logic pin_out, oe, tx_clk, rx_clk, tx_chg, rx_samp;
   logic [3:0] states;
   logic [1:0] mode;
   wire  logic pin_in;
   int   n_fail, n_tests, cyc;
   // The wire follows whichever side has the pin driven.
   assign pin_in = oe ? pin_out : ext_pin;
   ucg_clock_gen dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .sync_mode_select_in(sm),
      .double_speed_select_in(ds), .xfer_clock_direction_in(dir),
      .sync_clock_polarity_in(pol), .baud_divisor_high_in(hi), .baud_divisor_low_in(lo),
      .divisor_low_wr_in(wr), .transfer_clock_pin_in(pin_in), .transfer_clock_pin_out(pin_out),
      .transfer_clock_pin_oe_out(oe), .tx_clk_out(tx_clk), .rx_clk_out(rx_clk),
      .tx_change_out(tx_chg), .rx_sample_out(rx_samp), .rx_states_m1_out(states),
      .mode_out(mode));
   ucg_ext_master ext (.clk_in(clk_in), .run_in(ext_run), .half_in(half), .pin_out(ext_pin));
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         complete_run();
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: return rx_clk;
         1: return tx_clk;
         2: return pin_out;
         3: return pin_in;
         4: return rx_samp;
         default: return tx_chg;
      endcase
   endfunction
   // Pulses count on their rising sample, pin levels on any change.
   task automatic edge_wait(input int s, output int c);
      logic p;
      logic v;
      p = sig(s);
      c = 0;
      while (c < 3000) begin
         @(negedge clk_in);
         c++;
         v = sig(s);
         if ((s == 2 || s == 3) ? (v !== p) : (v === 1'b1 && p !== 1'b1)) break;
         p = v;
      end
   endtask
   task automatic gap(input string nm, input int s, input int e);
      int c;
      edge_wait(s, c);
      edge_wait(s, c);
      chk(nm, 16'(e), 16'(c));
   endtask
   task automatic cfg(input logic a, b, d, p, input logic [11:0] v);
      @(posedge clk_in);
      {sm, ds, dir, pol, hi, lo, wr} <= {a, b, d, p, v, 1'b1};
      @(posedge clk_in);
      wr <= 1'b0;
      repeat (4) @(posedge clk_in);
   endtask
   task automatic t_async();
      ext_run <= 1'b1; // Edges on the pin must be ignored here.
      cfg(1'b0, 1'b0, 1'b0, 1'b0, 12'h001);
      chk("mode", 16'(UCG_MODE_ASYNC_NORMAL), 16'(mode));
      chk("states", 16'(UCG_FACTOR_NORMAL), 16'(states));
      chk("oe", 16'h0000, 16'(oe));
      gap("rx_gap", 0, 2);
      gap("tx_gap", 1, 32);
      cfg(1'b0, 1'b1, 1'b1, 1'b0, 12'h002);
      chk("mode", 16'(UCG_MODE_ASYNC_DOUBLE), 16'(mode));
      chk("states", 16'(UCG_FACTOR_DOUBLE), 16'(states));
      chk("oe", 16'h0000, 16'(oe));
      gap("rx_gap", 0, 3);
      gap("tx_gap", 1, 24);
      ext_run <= 1'b0;
      $display("async modes done");
   endtask
   task automatic t_master();
      int c;
      cfg(1'b1, 1'b1, 1'b1, 1'b0, 12'h001); // Double speed must be ignored.
      chk("mode", 16'(UCG_MODE_SYNC_MASTER), 16'(mode));
      chk("states", 16'(UCG_FACTOR_SYNC), 16'(states));
      chk("oe", 16'h0001, 16'(oe));
      gap("tx_gap", 1, 4);
      gap("pin_half", 2, 2);
      edge_wait(5, c);
      chk("change_lvl", 16'h0001, 16'(pin_out));
      edge_wait(4, c);
      chk("sample_lvl", 16'h0000, 16'(pin_out));
      $display("master mode done");
   endtask
   task automatic t_slave();
      int c;
      for (int p = 0; p < 2; p++) begin
         cfg(1'b1, 1'b0, 1'b0, 1'(p), 12'h005);
         ext_run <= 1'b1;
         chk("mode", 16'(UCG_MODE_SYNC_SLAVE), 16'(mode));
         chk("oe", 16'h0000, 16'(oe));
         chk("states", 16'(UCG_FACTOR_SYNC), 16'(states));
         gap("tx_gap", 1, 4);
         gap("rx_gap", 0, 4);
         edge_wait(3, c);
         edge_wait(1, c);
         chk("delay", 16'h0003, 16'(c));
         edge_wait(4, c);
         chk("sample_lvl", 16'(p), 16'(pin_in));
         edge_wait(5, c);
         chk("change_lvl", 16'(1 - p), 16'(pin_in));
         ext_run <= 1'b0;
      end
      $display("slave mode done");
   endtask
   task automatic t_reload();
      int k;
      k = 0;
      cfg(1'b0, 1'b0, 1'b0, 1'b0, 12'h100);
      gap("rx_gap", 0, 257);
      @(posedge clk_in);
      lo <= 8'h09;
      hi <= 4'h0;
      wr <= 1'b1;
      // Writes every four cycles keep a divisor of 9 from ever reaching zero.
      for (int j = 1; j <= 40; j++) begin
         @(negedge clk_in);
         if (rx_clk === 1'b1) k++;
         @(posedge clk_in);
         wr <= (j % 4 == 0);
      end
      @(posedge clk_in);
      wr <= 1'b0;
      chk("no_tick", 16'h0000, 16'(k));
      gap("rx_gap", 0, 10);
      $display("reload done");
   endtask
   initial begin
      {rst_b_in, sm, ds, dir, pol, wr, ext_run, hi, lo} = '0;
      half = 4'h4;
      n_fail = 0;
      n_tests = 0;
      cyc = 0;
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      chk("rst_tx", 16'h0000, 16'(tx_clk));
      chk("rst_states", 16'h000f, 16'(states));
      @(posedge clk_in);
      rst_b_in <= 1'b1;
      $display("reset done");
      t_async();
      t_master();
      t_slave();
      t_reload();
      complete_run();
   end
endmodule
